// File: rtl/tsadc_consts.svh
/*
 * constants for the two-step converter timing model: widths, fifo shape,
 * clock rate and pipeline timing.
 * assumes it is included by bare name from rtl/ and never stands alone.
 */
`ifndef TSADC_CONSTS_SVH
`define TSADC_CONSTS_SVH

// ************************************************************
// widths, field positions and fine stage count
// ************************************************************
`define TSADC_WORD_W        8
`define TSADC_PART_W        4
`define TSADC_UPPER_MSB     7
`define TSADC_UPPER_LSB     4
`define TSADC_NUM_FINE      2

// ************************************************************
// reset and saturation values
// ************************************************************
`define TSADC_WORD_RST      8'h00
`define TSADC_PART_RST      4'h0
`define TSADC_PART_MAX      4'hf

// ************************************************************
// fifo shape
// ************************************************************
`define TSADC_FIFO_DEPTH    32
// five words can still be in flight once ready drops: three pipeline
// stages plus the fifo ready flop and its copy at the top port
`define TSADC_FIFO_SLACK    5

// ************************************************************
// timing
// ************************************************************
`define TSADC_CLK_MHZ       50
`define TSADC_CLK_PERIOD_NS 20
`define TSADC_LATENCY_HALF  5
`define TSADC_MIN_RATE_MSPS 0.5

`endif

// File: rtl/tsadc_pkg.sv
/*
 * types shared by the two-step converter timing model.
 * assumes tsadc_consts.svh is reachable on the include path.
 */
`include "tsadc_consts.svh"

package tsadc_pkg;

  // one partial result, upper or lower half of the word
  typedef logic [`TSADC_PART_W-1:0] tsadc_part_t;

  // merged straight-binary output word
  typedef logic [`TSADC_WORD_W-1:0] tsadc_word_t;

  // which fine stage a sample is assigned to
  typedef enum logic {
    TSADC_FINE_A = 1'b0,
    TSADC_FINE_B = 1'b1
  } tsadc_stage_t;

endpackage

// File: rtl/tsadc_top.sv
/*
 * two-step converter timing model: coarse stage, two alternating fine
 * stages, word merge and a 32-word output fifo.
 * assumes analog_level_i carries the input level already quantised to the
 * word width, bottom reference as 0 and top reference as all ones, stable
 * around each falling edge of clk_i; the clock runs free and fast enough.
 */
`timescale 1ns/1ps
`include "tsadc_consts.svh"

// ************************************************************
// output fifo
// ************************************************************
module tsadc_fifo #(
  parameter int WIDTH = `TSADC_WORD_W,
  parameter int DEPTH = `TSADC_FIFO_DEPTH,
  parameter int SLACK = `TSADC_FIFO_SLACK
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             full;
  logic             push;
  logic             pop;

  // full is honest: the array itself has no room left
  assign full = (count_reg == (AW+1)'(DEPTH));
  assign push = in_valid_i && !full;
  // refill the output register when it is empty or being taken
  assign pop  = (count_reg != '0) && (!out_valid_o || out_ready_i);

  // occupancy of the array, not counting the output register
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  // storage; no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
    end
  end

  // ready drops early by SLACK words: a source cannot stall words already
  // inside a fixed-latency pipeline, so that much headroom is kept back
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_ready_o <= 1'b0;
    end else begin
      in_ready_o <= (count_next < (AW+1)'(DEPTH - SLACK));
    end
  end

  // registered output stage, so the port comes straight from a flop
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o  <= mem_reg[rd_ptr_reg];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule

// ************************************************************
// converter pipeline
// ************************************************************
module tsadc_top #(
  parameter int FIFO_DEPTH = `TSADC_FIFO_DEPTH
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire tsadc_pkg::tsadc_word_t   analog_level_i,
  input  wire logic                     sample_valid_i,
  output logic                          sample_ready_o,
  output tsadc_pkg::tsadc_word_t        word_o,
  output logic                          word_valid_o,
  output tsadc_pkg::tsadc_word_t        buf_data_o,
  output logic                          buf_valid_o,
  input  wire logic                     buf_ready_i,
  output logic                          overrun_o
);

  // fine comparator: distance of the held level above the applied
  // reference, saturated to the fine range like a thermometer bank
  function automatic tsadc_pkg::tsadc_part_t fine_compare(
    input tsadc_pkg::tsadc_word_t level,
    input tsadc_pkg::tsadc_word_t ref_lvl
  );
    tsadc_pkg::tsadc_word_t diff;
    diff = level - ref_lvl;
    if (level < ref_lvl) begin
      fine_compare = `TSADC_PART_RST;
    end else if (diff > tsadc_pkg::tsadc_word_t'(`TSADC_PART_MAX)) begin
      fine_compare = `TSADC_PART_MAX;
    end else begin
      fine_compare = diff[`TSADC_PART_W-1:0];
    end
  endfunction

  tsadc_pkg::tsadc_word_t  coarse_hold_reg;
  logic                    coarse_vld_reg;
  tsadc_pkg::tsadc_stage_t assign_reg;
  tsadc_pkg::tsadc_word_t  fine_hold_reg [`TSADC_NUM_FINE];
  tsadc_pkg::tsadc_word_t  fine_reference_level_reg [`TSADC_NUM_FINE];
  tsadc_pkg::tsadc_part_t  upper_partial_result_reg;
  tsadc_pkg::tsadc_part_t  upper_delay_reg;
  tsadc_pkg::tsadc_part_t  lower_partial_result_reg;
  tsadc_pkg::tsadc_stage_t resolve_stage_reg;
  logic                    stage1_vld_reg;
  logic                    stage2_vld_reg;
  logic                    fifo_ready;
  logic                    ready_seen_reg;

  // ----------------------------------------------------------
  // falling edge: sampling
  // ----------------------------------------------------------

  // coarse stage takes the sample on the falling edge
  always_ff @(negedge clk_i) begin
    if (!rst_b_i) begin
      coarse_hold_reg <= `TSADC_WORD_RST;
      coarse_vld_reg  <= 1'b0;
    end else begin
      coarse_hold_reg <= analog_level_i;
      coarse_vld_reg  <= sample_valid_i;
    end
  end

  // fine stages take turns; the assignment flips every falling edge so
  // one stage holds for resolution while the other samples
  always_ff @(negedge clk_i) begin
    if (!rst_b_i) begin
      assign_reg <= tsadc_pkg::TSADC_FINE_B;
    end else begin
      assign_reg <= (assign_reg == tsadc_pkg::TSADC_FINE_A) ?
                    tsadc_pkg::TSADC_FINE_B : tsadc_pkg::TSADC_FINE_A;
    end
  end

  // each fine stage captures the same value as the coarse stage, but only
  // on the edge it is assigned to; it then holds across two rising edges
  for (genvar g = 0; g < `TSADC_NUM_FINE; g++) begin : g_fine_hold
    always_ff @(negedge clk_i) begin
      if (!rst_b_i) begin
        fine_hold_reg[g] <= `TSADC_WORD_RST;
      end else if (assign_reg != tsadc_pkg::tsadc_stage_t'(g)) begin
        fine_hold_reg[g] <= analog_level_i;
      end
    end
  end

  // ----------------------------------------------------------
  // first rising edge: coarse result and fine reference
  // ----------------------------------------------------------

  // after the falling edge assign_reg already names the stage that sampled
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      upper_partial_result_reg <= `TSADC_PART_RST;
      resolve_stage_reg        <= tsadc_pkg::TSADC_FINE_A;
      stage1_vld_reg           <= 1'b0;
    end else begin
      upper_partial_result_reg <=
        coarse_hold_reg[`TSADC_UPPER_MSB:`TSADC_UPPER_LSB];
      resolve_stage_reg        <= assign_reg;
      stage1_vld_reg           <= coarse_vld_reg;
    end
  end

  // reference for the stage that just sampled (named by assign_reg) follows
  // the coarse result on the same edge; the other keeps its reference
  for (genvar g = 0; g < `TSADC_NUM_FINE; g++) begin : g_fine_ref
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        fine_reference_level_reg[g] <= `TSADC_WORD_RST;
      end else if (assign_reg == tsadc_pkg::tsadc_stage_t'(g)) begin
        fine_reference_level_reg[g] <=
          {coarse_hold_reg[`TSADC_UPPER_MSB:`TSADC_UPPER_LSB],
           `TSADC_PART_RST};
      end
    end
  end

  // ----------------------------------------------------------
  // second rising edge: fine result
  // ----------------------------------------------------------

  // the resolving stage is not resampled before this edge, which is why
  // two stages are needed to keep one sample per clock
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lower_partial_result_reg <= `TSADC_PART_RST;
      upper_delay_reg          <= `TSADC_PART_RST;
      stage2_vld_reg           <= 1'b0;
    end else begin
      lower_partial_result_reg <= fine_compare(
        fine_hold_reg[resolve_stage_reg],
        fine_reference_level_reg[resolve_stage_reg]);
      upper_delay_reg          <= upper_partial_result_reg;
      stage2_vld_reg           <= stage1_vld_reg;
    end
  end

  // ----------------------------------------------------------
  // third rising edge: merged word
  // ----------------------------------------------------------

  // coarse bits on top, fine below; straight binary, no offset applied.
  // falling-edge sample plus three rising edges gives five half cycles.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      word_o       <= `TSADC_WORD_RST;
      word_valid_o <= 1'b0;
    end else begin
      word_o       <= {upper_delay_reg, lower_partial_result_reg};
      word_valid_o <= stage2_vld_reg;
    end
  end

  // ----------------------------------------------------------
  // buffering
  // ----------------------------------------------------------

  // the pipeline cannot stall; ready to the source covers in-flight words
  tsadc_fifo #(
    .WIDTH (`TSADC_WORD_W),
    .DEPTH (FIFO_DEPTH),
    .SLACK (`TSADC_FIFO_SLACK)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (word_o),
    .in_valid_i  (word_valid_o),
    .in_ready_o  (fifo_ready),
    .out_data_o  (buf_data_o),
    .out_valid_o (buf_valid_o),
    .out_ready_i (buf_ready_i)
  );

  // ready is already a flop inside the fifo; copied once more here so the
  // top port stays a flop of this module
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sample_ready_o <= 1'b0;
    end else begin
      sample_ready_o <= fifo_ready;
    end
  end

  // ready as the source saw it when launching the sample now held in the
  // coarse stage: the value that stood before the previous rising edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ready_seen_reg <= 1'b0;
    end else begin
      ready_seen_reg <= sample_ready_o;
    end
  end

  // sticky flag: a sample was taken although ready had been low. the slack
  // covers every word an obedient source still has in flight, so such a
  // sample always comes before any lost word; the reverse need not hold.
  // limitation: only reset clears it, there is no software access
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      overrun_o <= 1'b0;
    end else if (coarse_vld_reg && !ready_seen_reg) begin
      overrun_o <= 1'b1;
    end
  end

  // held comparator states rely on the clock never stopping for long,
  // so no idle or hold logic exists here

endmodule

// File: dv/tsadc_checker.sv
/* checker for the converter pipeline ports.
   assumes it is bound to tsadc_top, sync active-low reset. */
`timescale 1ns/1ps
module tsadc_checker (
  input wire logic                   clk_i,
  input wire logic                   rst_b_i,
  input wire tsadc_pkg::tsadc_word_t analog_level_i,
  input wire logic                   sample_valid_i,
  input wire logic                   sample_ready_o,
  input wire tsadc_pkg::tsadc_word_t word_o,
  input wire logic                   word_valid_o,
  input wire tsadc_pkg::tsadc_word_t buf_data_o,
  input wire logic                   buf_valid_o,
  input wire logic                   buf_ready_i,
  input wire logic                   overrun_o
);
  // ************************************************************
  // falling-edge mirror and assertions
  // ************************************************************
  logic [7:0] s_lvl;
  logic       s_vld;
  logic [3:0] s_up;
  logic [3:0] s_lo;
  // copy of what was sampled, so rising-edge checks can see it
  always_ff @(negedge clk_i) begin
    s_lvl <= analog_level_i;
    s_vld <= sample_valid_i & rst_b_i; // a sample under reset is lost
  end
  assign s_up = s_lvl[7:4];
  assign s_lo = s_lvl[3:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // a falling-edge sample is seen at the next tick; its word is launched on
  // the third rising edge and so is seen three ticks after that
  sequence taken;
    $past(s_vld, 3);
  endsequence
  chk_word_latency: assert property (taken |-> word_valid_o && word_o == $past(s_lvl, 3))
    else $error("word late or wrong");
  chk_no_extra: assert property (!$past(s_vld, 3) |-> !word_valid_o)
    else $error("word without sample");
  chk_upper_half: assert property (word_valid_o |-> word_o[7:4] == $past(s_up, 3))
    else $error("upper half wrong");
  chk_lower_half: assert property (word_valid_o |-> word_o[3:0] == $past(s_lo, 3))
    else $error("lower half wrong");
  chk_code_top: assert property (taken ##0 ($past(s_lvl, 3) == 8'hff) |-> word_o == 8'hff)
    else $error("top code wrong");
  chk_buf_hold: assert property (buf_valid_o && !buf_ready_i |=> buf_valid_o && $stable(buf_data_o))
    else $error("buffer head moved");
  chk_buf_fill: assert property (word_valid_o && sample_ready_o && !buf_valid_o |-> ##[1:2] buf_valid_o)
    else $error("buffer head late");
  chk_overrun_sticky: assert property (overrun_o |=> overrun_o)
    else $error("overrun dropped");
  chk_reset_quiet: assert property (disable iff (1'b0)
    !rst_b_i |=> !word_valid_o && !buf_valid_o && !sample_ready_o && !overrun_o)
    else $error("outputs not cleared");
endmodule
bind tsadc_top tsadc_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .analog_level_i(analog_level_i),
  .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .word_o(word_o),
  .word_valid_o(word_valid_o), .buf_data_o(buf_data_o), .buf_valid_o(buf_valid_o),
  .buf_ready_i(buf_ready_i), .overrun_o(overrun_o));

// File: dv/tsadc_sink.sv
/* capture model of the logic reading the output buffer.
   assumes stall_i from the bench picks prompt takes or no takes at all. */
`timescale 1ns/1ps
module tsadc_sink (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire tsadc_pkg::tsadc_word_t data_i,
  input  wire logic                   valid_i,
  input  wire logic                   stall_i,
  output logic                        ready_o
);
  tsadc_pkg::tsadc_word_t q[$];
  // ready moves only after an edge, so a word is never half taken
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b0;
      q.delete();
    end else begin
      ready_o <= !stall_i;
      if (valid_i && ready_o) q.push_back(data_i);
    end
  end
endmodule

// File: dv/two_step_adc_sample_pipeline_tb.sv
/* self-checking bench for the converter pipeline and its buffer.
   assumes tsadc_top, tsadc_sink and the bound checker. */
`timescale 1ns/1ps
module two_step_adc_sample_pipeline_tb;
  logic                   clk_i, rst_b_i, sample_valid_i, buf_ready_i, stall;
  logic                   sample_ready_o, word_valid_o, buf_valid_o, overrun_o;
  tsadc_pkg::tsadc_word_t analog_level_i, word_o, buf_data_o;
  tsadc_pkg::tsadc_word_t exp_q[$];
  int                     failures = 0, n_compared = 0, cycles = 0;
  tsadc_top #(.FIFO_DEPTH(8)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .analog_level_i(analog_level_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .word_o(word_o),
    .word_valid_o(word_valid_o), .buf_data_o(buf_data_o), .buf_valid_o(buf_valid_o),
    .buf_ready_i(buf_ready_i), .overrun_o(overrun_o));
  tsadc_sink sink (.clk_i(clk_i), .rst_b_i(rst_b_i), .data_i(buf_data_o), .valid_i(buf_valid_o),
    .stall_i(stall), .ready_o(buf_ready_i));
  // free-running 50 MHz clock, well above the minimum rate
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, sized well above the whole sequence
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      $display("Error at %0t: run too long", $time);
      end_sim();
    end
  end
  task automatic do_reset();
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    sample_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    exp_q.delete();
    for (int k = 0; k < 20 && sample_ready_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    cmp(sample_ready_o, 1'b1, "ready after reset");
  endtask
  // up to n samples from base by step (none while ready low if obey); word checked three rising edges later
  task automatic send(input int n, input logic [7:0] base, input logic [7:0] step, input bit obey);
    logic [7:0] hl[64];
    logic       hv[64];
    logic       rdy;
    rdy = sample_ready_o;
    for (int i = 0; i < n + 3; i++) begin
      @(posedge clk_i);
      hv[i] = (i < n) && (rdy || !obey);
      hl[i] = hv[i] ? base + step * i[7:0] : ~analog_level_i;
      sample_valid_i <= hv[i];
      analog_level_i <= hl[i];
      if (hv[i]) exp_q.push_back(hl[i]);
      #1;
      if (i >= 3) begin
        cmp(word_valid_o, hv[i-3], "word valid");
        if (hv[i-3]) cmp(word_o, hl[i-3], "word");
      end
      rdy = sample_ready_o;
    end
  endtask
  task automatic check_capture();
    for (int k = 0; k < 200 && sink.q.size() < exp_q.size(); k++) begin
      @(posedge clk_i);
      #1;
    end
    cmp(sink.q.size(), exp_q.size(), "captured count");
    while (exp_q.size() > 0 && sink.q.size() > 0) cmp(sink.q.pop_front(), exp_q.pop_front(), "order");
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_codes();
    stall = 1'b0;
    send(16, 8'h00, 8'h11, 1'b1);
    send(4, 8'h7e, 8'h01, 1'b1);
    check_capture();
  endtask
  task automatic t_fill();
    stall = 1'b1;
    send(24, 8'h40, 8'h03, 1'b1);
    cmp(sample_ready_o, 1'b0, "ready while full");
    cmp(overrun_o, 1'b0, "no overrun when obeyed");
    stall = 1'b0;
    check_capture();
    repeat (4) @(posedge clk_i);
    #1;
    cmp(buf_valid_o, 1'b0, "drained");
  endtask
  task automatic t_overrun();
    stall = 1'b1;
    send(20, 8'h90, 8'h01, 1'b0);
    cmp(overrun_o, 1'b1, "overrun set");
    stall = 1'b0;
    do_reset();
    cmp(overrun_o, 1'b0, "overrun cleared");
    cmp(buf_valid_o, 1'b0, "buffer empty");
    send(3, 8'h5a, 8'h01, 1'b1);
    check_capture();
  endtask
  initial begin
    rst_b_i = 1'b0;
    sample_valid_i = 1'b0;
    analog_level_i = 8'h00;
    stall = 1'b0;
    do_reset();
    t_codes();
    t_fill();
    t_overrun();
    end_sim();
  end
endmodule
